// [bench/ppe_properties.sv]
// Port-level checker for ppe_top, shadowing both pull registers.
// Assumes the bench keeps strobes off until three edges after reset release.
`timescale 1ns/1ps
module ppe_properties #(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [W-1:0] first_port_dir,
    input wire logic [W-1:0] first_port_hiz,
    input wire logic [W-1:0] first_port_drive,
    input wire logic [W-1:0] first_port_serial_sel,
    input wire logic [W-1:0] second_port_dir,
    input wire logic [W-1:0] second_port_hiz,
    input wire logic [W-1:0] first_port_pins_pull_up,
    input wire logic [W-1:0] second_port_pins_pull_up
);
    logic [W-1:0] sh_a_reg, sh_b_reg, ser, exp_a, exp_b, low_m, hi_m;
    logic mapped;
    always_comb begin
        ser = first_port_serial_sel & W'(ppe_pkg::PORT_A_OD_MASK);
        exp_a = (sh_a_reg & ~first_port_dir & ~first_port_hiz & ~ser);
        exp_a = exp_a | (sh_a_reg & first_port_drive & ser);
        exp_b = sh_b_reg & ~second_port_dir & ~second_port_hiz;
        low_m = ser & ~first_port_drive;
        hi_m = ser & first_port_drive & sh_a_reg;
        mapped = reg_addr inside {ppe_pkg::PORT_A_PULL_OFF, ppe_pkg::PORT_B_PULL_OFF,
            ppe_pkg::PORT_A_STAT_OFF, ppe_pkg::PORT_B_STAT_OFF, ppe_pkg::ACCESS_ERR_OFF};
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sh_a_reg <= '0;
            sh_b_reg <= '0;
        end else if (reg_wr && reg_addr == ppe_pkg::PORT_A_PULL_OFF) begin
            sh_a_reg <= W'(reg_wdata & ppe_pkg::PORT_A_WMASK);
        end else if (reg_wr && reg_addr == ppe_pkg::PORT_B_PULL_OFF) begin
            sh_b_reg <= W'(reg_wdata);
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    a_read_porta: assert property ($past(reg_rd) && $past(reg_addr) == 16'h30F0
        |-> reg_rdata == $past(sh_a_reg)) else $error("port A read wrong");
    a_read_portb: assert property ($past(reg_rd) && $past(reg_addr) == 16'h30F1
        |-> reg_rdata == $past(sh_b_reg)) else $error("port B read wrong");
    a_unmapped_zero: assert property ($past(reg_rd) && !$past(mapped) |-> !reg_rdata)
        else $error("unmapped read not zero");
    a_pull_porta: assert property (first_port_pins_pull_up == $past(exp_a))
        else $error("port A pull-up wrong");
    a_pull_portb: assert property (second_port_pins_pull_up == $past(exp_b))
        else $error("port B pull-up wrong");
    a_serial_low: assert property (low_m != 0 |=> !(first_port_pins_pull_up & $past(low_m)))
        else $error("serial low pull-up on");
    a_serial_high: assert property (hi_m != 0 |=> (first_port_pins_pull_up & $past(hi_m))
        == $past(hi_m)) else $error("serial high pull-up off");
    c_read_a: cover property (reg_rd && reg_addr == 16'h30F0);
    c_ser_low: cover property (low_m != 0);
    c_rsvd_wr: cover property (reg_wr && reg_addr == 16'h30F0 && reg_wdata[4]);
endmodule : ppe_properties
bind ppe_top ppe_properties #(.W(W)) ppe_properties_inst (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .first_port_dir(first_port_dir), .first_port_hiz(first_port_hiz),
    .first_port_drive(first_port_drive), .first_port_serial_sel(first_port_serial_sel),
    .second_port_dir(second_port_dir), .second_port_hiz(second_port_hiz),
    .first_port_pins_pull_up(first_port_pins_pull_up),
    .second_port_pins_pull_up(second_port_pins_pull_up));

// [bench/tb_top.sv]
// Self-checking bench for ppe_top: register traffic, pin states, resets.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, a_pu, b_pu, m_a, m_b, m_err;
    logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
    logic [7:0] a_dir = 8'h00, a_hiz = 8'h00, a_drv = 8'h00, a_sel = 8'h00;
    logic [7:0] b_dir = 8'h00, b_hiz = 8'h00, b_drv = 8'h00;
    logic [31:0] seed = 32'h8871;
    // Reference copies of the pull registers and the pull-up levels due one edge later.
    logic [7:0] ra = 8'h00, rb = 8'h00, pa_exp = 8'h00, pb_exp = 8'h00;
    logic [7:0] exp_q[$];
    logic [15:0] map_l[5] = '{16'h30F0, 16'h30F1, 16'h30F8, 16'h30F9, 16'h30FA};
    int num_errors = 0, total_checks = 0;
    ppe_top ppe_top_inst (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .first_port_dir(a_dir), .first_port_hiz(a_hiz), .first_port_drive(a_drv),
        .first_port_serial_sel(a_sel), .second_port_dir(b_dir), .second_port_hiz(b_hiz),
        .second_port_drive(b_drv), .first_port_pins_pull_up(a_pu),
        .second_port_pins_pull_up(b_pu));
    initial forever #12.5 clock = ~clock;
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction : rnd
    function automatic logic [7:0] pull_a();
        logic [7:0] s;
        s = a_sel & 8'h0C;
        return (m_a & ~a_dir & ~a_hiz & ~s) | (m_a & a_drv & s);
    endfunction : pull_a
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        total_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic wr(input logic [15:0] ad, input logic [7:0] d);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        if (ad == 16'h30F0) m_a = d & 8'hEF;
        if (ad == 16'h30F0) m_err[1] = m_err[1] | d[4];
        if (ad == 16'h30F1) m_b = d;
        if (ad == 16'h30FA) m_err = m_err & ~d;
        if (!(ad inside {map_l})) m_err[0] = 1'b1;
        @(posedge clock);
    endtask : wr
    task automatic rd(input logic [15:0] ad);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        case (ad)
            16'h30F0: exp_q.push_back(m_a);
            16'h30F1: exp_q.push_back(m_b);
            16'h30F8: exp_q.push_back(pull_a());
            16'h30F9: exp_q.push_back(m_b & ~b_dir & ~b_hiz);
            16'h30FA: exp_q.push_back(m_err);
            default: begin
                exp_q.push_back(8'h00);
                m_err[0] = 1'b1;
            end
        endcase
        @(posedge clock);
    endtask : rd
    task automatic idle();
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask : idle
    task automatic do_reset();
        rst_n <= 1'b0;
        m_a = 8'h00;
        m_b = 8'h00;
        m_err = 8'h00;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
    endtask : do_reset
    task automatic close_out();
        if (num_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out
    always @(posedge clock) begin
        if (rd_d) check(reg_rdata, exp_q.pop_front());
        else if (rst_n) check(reg_rdata, 8'h00);
        if (rst_n) check(a_pu, pa_exp);
        if (rst_n) check(b_pu, pb_exp);
        pa_exp <= (ra & ~a_dir & ~a_hiz & ~(a_sel & 8'h0C)) | (ra & a_drv & a_sel & 8'h0C);
        pb_exp <= rb & ~b_dir & ~b_hiz;
        if (!rst_n) begin
            ra <= 8'h00;
            rb <= 8'h00;
        end else if (reg_wr && reg_addr == 16'h30F0) begin
            ra <= reg_wdata & 8'hEF;
        end else if (reg_wr && reg_addr == 16'h30F1) begin
            rb <= reg_wdata;
        end
        rd_d <= reg_rd;
    end
    initial begin
        repeat (5000) @(posedge clock);
        num_errors++;
        close_out();
    end
    initial begin
        do_reset();
        foreach (map_l[i]) rd(map_l[i]);
        // Pins change with the first write; status reads are strobed on the fifth and sixth edges after.
        repeat (24) begin
            a_dir <= rnd() & rnd();
            a_hiz <= rnd() & rnd();
            a_drv <= rnd();
            a_sel <= rnd();
            b_dir <= rnd() & rnd();
            b_hiz <= rnd() & rnd();
            b_drv <= rnd();
            wr(16'h30F0, rnd());
            wr(16'h30F1, rnd());
            foreach (map_l[i]) rd(map_l[i]);
        end
        rd(16'h30F2);
        wr(16'h0000, 8'h5A);
        rd(16'h30FA);
        wr(16'h30FA, 8'hFF);
        rd(16'h30FA);
        wr(16'h30F8, 8'hFF);
        rd(16'h30F8);
        repeat (2) idle();
        do_reset();
        foreach (map_l[i]) rd(map_l[i]);
        repeat (3) idle();
        close_out();
    end
endmodule : tb_top

// [hw/ppe_pin_pull.sv]
// Per-pin pull-up gating for one port.
// Assumes direction, high-impedance, drive and serial-select come from same-clock logic.
`timescale 1ns/1ps
module ppe_pin_pull #(
    parameter int W = 8,
    parameter logic [W-1:0] OD_MASK = '0
) (
    input wire logic [W-1:0] pull_bits,
    input wire logic [W-1:0] pin_dir,
    input wire logic [W-1:0] pin_hiz,
    input wire logic [W-1:0] pin_drive,
    input wire logic [W-1:0] serial_sel,
    output logic [W-1:0] pull_on
);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_pin
            if (OD_MASK[i]) begin : g_od
                // Serial use: pull stays on while released high, off while driving low.
                always_comb begin
                    if (serial_sel[i]) begin
                        pull_on[i] = pull_bits[i] & pin_drive[i]; // RQ3 RQ4 RQ7
                    end else begin
                        pull_on[i] = pull_bits[i] & ~pin_dir[i] & ~pin_hiz[i]; // RQ2
                    end
                end
            end else begin : g_std
                // Pull applies to inputs only.
                always_comb begin
                    pull_on[i] = pull_bits[i] & ~pin_dir[i] & ~pin_hiz[i]; // RQ2
                end
            end
        end
    endgenerate

endmodule : ppe_pin_pull

// [hw/ppe_pull_reg.sv]
// One byte-wide pull enable register with a writable-bit mask.
// Assumes a reset already synchronised to clock and a one-cycle write enable.
`timescale 1ns/1ps
module ppe_pull_reg #(
    parameter int W = 8,
    parameter logic [W-1:0] WMASK = '1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] value
);

    logic [W-1:0] value_reg;
    logic [W-1:0] value_next;

    // Bits outside the mask keep their reset value, so they always read as RST_VAL.
    always_comb begin
        value_next = value_reg;
        if (wr_en) begin
            value_next = (wdata & WMASK) | (RST_VAL & ~WMASK);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            value_reg <= RST_VAL;
        end else begin
            value_reg <= value_next;
        end
    end

    assign value = value_reg;

endmodule : ppe_pull_reg

// [hw/ppe_top.sv]
// Pull-up enable registers and pull-up control for two 8-bit ports.
// Assumes pin direction, drive and mux controls arrive from logic on clock.
// Contract
// [RQ1] Port A pull bit 1 enables its pin pull-up; 0 disables it.
// [RQ2] Pull bit has no effect on output or high-impedance pins; inputs only.
// [RQ3] Port A pin 2 serial output high keeps pull-up while its bit is set.
// [RQ4] Serial pin driving low turns its pull-up off regardless of the bit.
// [RQ5] Port B has 8-bit read/write pull register, bit n for pin n, reset 0.
// [RQ6] Port B pull bit 1 enables its pin pull-up; 0 disables it.
// [RQ7] Port A pin 3 behaves like pin 2 for serial bus use.
// [RQ8] Port A bit 4 reserved, reads 0; other bits read/write, reset 0.
// [RQ9] Write updates addressed register that cycle; read returns current contents.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module ppe_top #(
    parameter int W = ppe_pkg::PORT_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [ppe_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [ppe_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ppe_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [W-1:0] first_port_dir,
    input wire logic [W-1:0] first_port_hiz,
    input wire logic [W-1:0] first_port_drive,
    input wire logic [W-1:0] first_port_serial_sel,
    input wire logic [W-1:0] second_port_dir,
    input wire logic [W-1:0] second_port_hiz,
    input wire logic [W-1:0] second_port_drive,
    output logic [W-1:0] first_port_pins_pull_up,
    output logic [W-1:0] second_port_pins_pull_up
);

    // Reset release through two flops; assertion stays asynchronous.
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rst_sync_n;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_sync_n = rst_sync_reg;

    // Address decode, shared by the write and read paths.
    function automatic ppe_pkg::ppe_sel_e decode_addr(
        input logic [ppe_pkg::ADDR_W-1:0] addr
    );
        ppe_pkg::ppe_sel_e sel;
        sel = ppe_pkg::SEL_NONE;
        if (addr == ppe_pkg::PORT_A_PULL_OFF) begin
            sel = ppe_pkg::SEL_PORT_A;
        end else if (addr == ppe_pkg::PORT_B_PULL_OFF) begin
            sel = ppe_pkg::SEL_PORT_B;
        end else if (addr == ppe_pkg::PORT_A_STAT_OFF) begin
            sel = ppe_pkg::SEL_STAT_A;
        end else if (addr == ppe_pkg::PORT_B_STAT_OFF) begin
            sel = ppe_pkg::SEL_STAT_B;
        end else if (addr == ppe_pkg::ACCESS_ERR_OFF) begin
            sel = ppe_pkg::SEL_ERR;
        end
        return sel;
    endfunction : decode_addr

    ppe_pkg::ppe_sel_e bus_sel;
    logic wr_port_a;
    logic wr_port_b;
    logic wr_err;

    always_comb begin
        bus_sel = decode_addr(reg_addr);
        wr_port_a = reg_wr && (bus_sel == ppe_pkg::SEL_PORT_A); // RQ9
        wr_port_b = reg_wr && (bus_sel == ppe_pkg::SEL_PORT_B); // RQ9
        wr_err = reg_wr && (bus_sel == ppe_pkg::SEL_ERR);
    end

    // Pull enable registers.
    logic [W-1:0] port_a_pull_bits;
    logic [W-1:0] port_b_pull_bits;

    ppe_pull_reg #(
        .W(W),
        .WMASK(W'(ppe_pkg::PORT_A_WMASK)),
        .RST_VAL(W'(ppe_pkg::PORT_A_PULL_RST))
    ) u_port_a_reg (
        .clock(clock),
        .rst_n(rst_sync_n),
        .wr_en(wr_port_a), // RQ8
        .wdata(reg_wdata[W-1:0]),
        .value(port_a_pull_bits)
    );

    ppe_pull_reg #(
        .W(W),
        .WMASK(W'(ppe_pkg::PORT_B_WMASK)),
        .RST_VAL(W'(ppe_pkg::PORT_B_PULL_RST))
    ) u_port_b_reg (
        .clock(clock),
        .rst_n(rst_sync_n),
        .wr_en(wr_port_b), // RQ5
        .wdata(reg_wdata[W-1:0]),
        .value(port_b_pull_bits)
    );

    // Pin gating for each port.
    logic [W-1:0] port_a_pull_on;
    logic [W-1:0] port_b_pull_on;
    logic [W-1:0] port_b_serial_none;

    assign port_b_serial_none = '0;

    ppe_pin_pull #(
        .W(W),
        .OD_MASK(W'(ppe_pkg::PORT_A_OD_MASK))
    ) u_port_a_pull (
        .pull_bits(port_a_pull_bits), // RQ1
        .pin_dir(first_port_dir), // RQ2
        .pin_hiz(first_port_hiz), // RQ2
        .pin_drive(first_port_drive), // RQ3 RQ4 RQ7
        .serial_sel(first_port_serial_sel),
        .pull_on(port_a_pull_on)
    );

    ppe_pin_pull #(
        .W(W),
        .OD_MASK(W'(ppe_pkg::PORT_B_OD_MASK))
    ) u_port_b_pull (
        .pull_bits(port_b_pull_bits), // RQ6
        .pin_dir(second_port_dir), // RQ2
        .pin_hiz(second_port_hiz), // RQ2
        .pin_drive(second_port_drive),
        .serial_sel(port_b_serial_none),
        .pull_on(port_b_pull_on)
    );

    // Registered pull-up drive; the same flops are the status registers.
    logic [W-1:0] pull_a_reg;
    logic [W-1:0] pull_a_next;
    logic [W-1:0] pull_b_reg;
    logic [W-1:0] pull_b_next;

    always_comb begin
        pull_a_next = port_a_pull_on; // RQ1
        pull_b_next = port_b_pull_on; // RQ6
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pull_a_reg <= W'(ppe_pkg::PULL_STAT_RST);
            pull_b_reg <= W'(ppe_pkg::PULL_STAT_RST);
        end else begin
            pull_a_reg <= pull_a_next;
            pull_b_reg <= pull_b_next;
        end
    end

    assign first_port_pins_pull_up = pull_a_reg;
    assign second_port_pins_pull_up = pull_b_reg;

    // Sticky access errors: unmapped access, or a one written to the reserved bit.
    // Software clears a flag by writing one to it; a new error in that cycle wins.
    logic [ppe_pkg::DATA_W-1:0] err_reg;
    logic [ppe_pkg::DATA_W-1:0] err_next;
    logic [ppe_pkg::DATA_W-1:0] err_set;
    logic [ppe_pkg::DATA_W-1:0] err_clr;

    always_comb begin
        err_set = '0;
        err_set[ppe_pkg::ERR_UNMAPPED_BIT] = (reg_wr || reg_rd) &&
            (bus_sel == ppe_pkg::SEL_NONE);
        err_set[ppe_pkg::ERR_RSVD_BIT] = wr_port_a &&
            reg_wdata[ppe_pkg::PORT_A_RSVD_BIT];
        err_clr = '0;
        if (wr_err) begin
            err_clr = reg_wdata & ppe_pkg::ACCESS_ERR_MASK;
        end
        err_next = ((err_reg & ~err_clr) | err_set) & ppe_pkg::ACCESS_ERR_MASK;
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            err_reg <= ppe_pkg::ACCESS_ERR_RST;
        end else begin
            err_reg <= err_next;
        end
    end

    // Read data stands only in the cycle after the read strobe.
    logic [ppe_pkg::DATA_W-1:0] rdata_reg;
    logic [ppe_pkg::DATA_W-1:0] rdata_next;

    always_comb begin
        rdata_next = ppe_pkg::READ_IDLE;
        if (reg_rd) begin
            unique case (bus_sel)
                ppe_pkg::SEL_PORT_A: begin
                    rdata_next = ppe_pkg::DATA_W'(port_a_pull_bits); // RQ9 RQ8
                end
                ppe_pkg::SEL_PORT_B: begin
                    rdata_next = ppe_pkg::DATA_W'(port_b_pull_bits); // RQ9 RQ5
                end
                ppe_pkg::SEL_STAT_A: begin
                    rdata_next = ppe_pkg::DATA_W'(pull_a_reg);
                end
                ppe_pkg::SEL_STAT_B: begin
                    rdata_next = ppe_pkg::DATA_W'(pull_b_reg);
                end
                ppe_pkg::SEL_ERR: begin
                    rdata_next = err_reg;
                end
                ppe_pkg::SEL_NONE: begin
                    rdata_next = ppe_pkg::READ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata_reg <= ppe_pkg::READ_IDLE;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule : ppe_top

// [include/ppe_pkg.sv]
// Shared constants for the port pull-up enable block.
// Assumes a byte-wide register port with a 16-bit address on one clock.
package ppe_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PORT_W = 8;

    // Register addresses on the register port.
    localparam logic [15:0] PORT_A_PULL_OFF = 16'h30F0;
    localparam logic [15:0] PORT_B_PULL_OFF = 16'h30F1;
    localparam logic [15:0] PORT_A_STAT_OFF = 16'h30F8;
    localparam logic [15:0] PORT_B_STAT_OFF = 16'h30F9;
    localparam logic [15:0] ACCESS_ERR_OFF = 16'h30FA;

    // Reset values.
    localparam logic [7:0] PORT_A_PULL_RST = 8'h00;
    localparam logic [7:0] PORT_B_PULL_RST = 8'h00;
    localparam logic [7:0] PULL_STAT_RST = 8'h00;
    localparam logic [7:0] ACCESS_ERR_RST = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // Writable bits; bit 4 of port A is reserved and reads as zero.
    localparam int PORT_A_RSVD_BIT = 4;
    localparam logic [7:0] PORT_A_WMASK = 8'hEF;
    localparam logic [7:0] PORT_B_WMASK = 8'hFF;

    // Port A pins 2 and 3 are the open-drain serial bus pins.
    localparam int SER_PIN_SDA = 2;
    localparam int SER_PIN_SCL = 3;
    localparam logic [7:0] PORT_A_OD_MASK = 8'h0C;
    localparam logic [7:0] PORT_B_OD_MASK = 8'h00;

    // Access error flag positions.
    localparam int ERR_UNMAPPED_BIT = 0;
    localparam int ERR_RSVD_BIT = 1;
    localparam logic [7:0] ACCESS_ERR_MASK = 8'h03;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_PORT_A,
        SEL_PORT_B,
        SEL_STAT_A,
        SEL_STAT_B,
        SEL_ERR
    } ppe_sel_e;

endpackage : ppe_pkg
